//--- rtl/llcb_bank.sv
// llcb: legacy link configuration register bank and its decoded controls
`timescale 1ns/1ps
`include "llcb_cfg.svh"

// Contract
// RULE1 - eight fixed control pin orders by field
// RULE2 - each control pin driven when enabled
// RULE3 - rate range codes, auto detect at reset
// RULE4 - output disable bit turns outputs off
// RULE5 - prbs enable enters test, legacy in hbw; prbs_test_on is not gated by hbw
// RULE6 - port select picks port zero or one
// RULE7 - reverse rx, forward tx enables default on
// RULE8 - method bit omits register address
// RULE9 - ignore far starts without far master
// RULE10 - equalizer enable, manual boost code, reset nine
// RULE11 - high immunity bit loaded from strap
// RULE12 - retry and skew compensation enables
// RULE13 - sync bit source field decode
// RULE14 - double output and half rate bits
// RULE15 - bus width modes from two bits
// RULE16 - pixel check type, pin when local off
// RULE17 - input forwarding and frame sync enables
// RULE18 - packet mode and check length field
// RULE19 - local acknowledge when forward unavailable
// RULE20 - tracking bit drops line with frame lock
// RULE21 - error threshold register reset zero
// RULE22 - glitch filters and separate de enable
// RULE23 - prbs style bit, legacy in hbw
module llcb_bank
    import llcb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_ack_q,
    input wire logic [4:0] ctl_int,
    output logic [4:0] ctl_pin_o_q,
    output logic [4:0] ctl_pin_oe_q,
    input wire logic him_cfg_pin,
    input wire logic pix_check_pin,
    input wire logic local_side_on,
    input wire logic adaptive_eq_on,
    input wire logic fwd_avail,
    input wire logic far_start,
    output logic far_start_q,
    output logic local_ack_q,
    input wire logic hlock_in,
    input wire logic vlock_in,
    output logic hlock_q,
    input wire logic [7:0] err_count,
    output logic thr_reached_q,
    output llcb_link_s link_q
);

    // ----------------------------------------
    // storage and pin synchronisers
    // ----------------------------------------
    localparam logic [8*`LLCB_NREG-1:0] RST_VALS = `LLCB_RST_VALS;
    localparam logic [8*`LLCB_NREG-1:0] WR_MASKS = `LLCB_WR_MASKS;

    logic [7:0] regs_q [`LLCB_NREG];
    logic [1:0] him_sync_q;
    logic [1:0] pix_sync_q;
    logic him_done_q;
    logic [3:0] boost_q;
    llcb_link_s link_d;

    always_ff @(posedge clk_sys) begin
        him_sync_q <= {him_sync_q[0], him_cfg_pin};
        pix_sync_q <= {pix_sync_q[0], pix_check_pin};
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic [3:0] hit_ix;

    always_comb begin
        if (reg_addr == `LLCB_OFS_RATE) begin
            hit_ix = `LLCB_IX_RATE;
        end else if (reg_addr == `LLCB_OFS_CHAN) begin
            hit_ix = `LLCB_IX_CHAN;
        end else if (reg_addr == `LLCB_OFS_EQ) begin
            hit_ix = `LLCB_IX_EQ;
        end else if (reg_addr == `LLCB_OFS_RTX) begin
            hit_ix = `LLCB_IX_RTX;
        end else if (reg_addr == `LLCB_OFS_BUS) begin
            hit_ix = `LLCB_IX_BUS;
        end else if (reg_addr == `LLCB_OFS_SIDE) begin
            hit_ix = `LLCB_IX_SIDE;
        end else if (reg_addr == `LLCB_OFS_ACK) begin
            hit_ix = `LLCB_IX_ACK;
        end else if (reg_addr == `LLCB_OFS_THR) begin
            hit_ix = `LLCB_IX_THR;
        end else if (reg_addr == `LLCB_OFS_FILT) begin
            hit_ix = `LLCB_IX_FILT;
        end else if (reg_addr == `LLCB_OFS_ROUTE) begin
            hit_ix = `LLCB_IX_ROUTE;
        end else begin
            hit_ix = `LLCB_IX_NONE;
        end
    end

    wire hit = (hit_ix != `LLCB_IX_NONE);
    wire [7:0] rd_mux = hit ? regs_q[hit_ix] : 8'h00;
    wire wr_him = reg_wr && (hit_ix == `LLCB_IX_RTX);
    wire him_load = !him_done_q && !wr_him;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < `LLCB_NREG; i++) begin
                regs_q[i] <= RST_VALS[8*i +: 8];
            end
            him_done_q <= 1'b0;
        end else begin
            for (int i = 0; i < `LLCB_NREG; i++) begin
                if (reg_wr && hit_ix == 4'(i)) begin
                    regs_q[i] <= reg_wdata & WR_MASKS[8*i +: 8];
                end
            end
            if (him_load) begin
                regs_q[`LLCB_IX_RTX][`LLCB_B_HIGH_IMM] <= him_sync_q[1]; // RULE11
            end
            him_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
            reg_ack_q <= 1'b0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : reg_rdata_q;
            reg_ack_q <= reg_rd;
        end
    end

    // ----------------------------------------
    // field views
    // ----------------------------------------
    wire [7:0] r_rate = regs_q[`LLCB_IX_RATE];
    wire [7:0] r_chan = regs_q[`LLCB_IX_CHAN];
    wire [7:0] r_eq = regs_q[`LLCB_IX_EQ];
    wire [7:0] r_rtx = regs_q[`LLCB_IX_RTX];
    wire [7:0] r_bus = regs_q[`LLCB_IX_BUS];
    wire [7:0] r_side = regs_q[`LLCB_IX_SIDE];
    wire [7:0] r_ack = regs_q[`LLCB_IX_ACK];
    wire [7:0] r_thr = regs_q[`LLCB_IX_THR];
    wire [7:0] r_filt = regs_q[`LLCB_IX_FILT];
    wire [7:0] r_route = regs_q[`LLCB_IX_ROUTE];

    wire out_dis = r_chan[`LLCB_B_OUT_DIS];
    wire wide = r_bus[`LLCB_B_WIDE];
    wire hbw_eff = r_bus[`LLCB_B_HIGH_BW] && !wide;
    wire eq_run = r_eq[`LLCB_B_EQ_ON];
    wire boost_ok = r_eq[3:0] <= `LLCB_MAX_BOOST;

    // ----------------------------------------
    // control pin routing
    // ----------------------------------------
    function automatic logic [2:0] src_of(input logic [2:0] ord, input logic [2:0] pin);
        logic [3:0] s;
        s = 4'h0;
        if (!ord[2]) begin
            s = 4'(pin) + 4'h5 - 4'({2'b00, ord[1:0]});
        end else begin
            s = 4'h4 - 4'(pin) + 4'({2'b00, ord[1:0]});
        end
        if (s >= 4'h5) begin
            s = s - 4'h5;
        end
        return s[2:0];
    endfunction

    logic [4:0] pin_d;

    always_comb begin
        pin_d = 5'h00;
        for (int p = 0; p < 5; p++) begin
            pin_d[p] = ctl_int[src_of(r_route[7:5], 3'(p))]; // RULE1
        end
    end

    wire [4:0] oe_d = r_route[4:0] & {5{!out_dis}}; // RULE2 RULE4

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl_pin_o_q <= 5'h00;
            ctl_pin_oe_q <= 5'h00;
        end else begin
            ctl_pin_o_q <= pin_d;
            ctl_pin_oe_q <= oe_d;
        end
    end

    // ----------------------------------------
    // decoded link controls
    // ----------------------------------------
    llcb_sync_bit_source_e hv_d;
    llcb_chk_len_e chk_d;

    always_comb begin
        case (r_rtx[2:0]) // RULE13
            3'h0: hv_d = LLCB_HV_D18;
            3'h1: hv_d = LLCB_HV_D14;
            3'h2: hv_d = LLCB_HV_D12;
            3'h3: hv_d = LLCB_HV_D0;
            3'h6, 3'h7: hv_d = LLCB_HV_AUTO;
            default: hv_d = LLCB_HV_RSVD;
        endcase
        case (r_side[1:0]) // RULE18
            2'h0: chk_d = LLCB_CHK_1;
            2'h1: chk_d = LLCB_CHK_5;
            2'h2: chk_d = LLCB_CHK_8;
            default: chk_d = LLCB_CHK_RSVD;
        endcase
    end

    // reserved boost codes keep the last good one
    wire [3:0] boost_d = boost_ok ? r_eq[3:0] : boost_q; // RULE10

    always_comb begin
        link_d = link_q;
        link_d.rate = llcb_rate_e'(r_rate[1:0]); // RULE3
        link_d.outputs_off = out_dis; // RULE4
        link_d.prbs_test_on = r_chan[`LLCB_B_PRBS_ON]; // RULE5
        link_d.prbs_style = r_filt[`LLCB_B_PRBS_STY] && !hbw_eff; // RULE23
        link_d.side_port_select = r_chan[`LLCB_B_PORT_SEL]; // RULE6
        link_d.reverse_side_rx_on = r_chan[`LLCB_B_REV_RX]; // RULE7
        link_d.forward_side_tx_on = r_chan[`LLCB_B_FWD_TX]; // RULE7
        link_d.skip_reg_addr = r_eq[`LLCB_B_SKIP_ADDR]; // RULE8
        link_d.sync_tracking_style = r_eq[`LLCB_B_TRACK_STY];
        link_d.equalizer_run = eq_run; // RULE10
        link_d.manual_boost = (eq_run && !adaptive_eq_on) ? boost_d : 4'h0; // RULE10
        link_d.high_immunity = r_rtx[`LLCB_B_HIGH_IMM]; // RULE11
        link_d.retry_limit_on = r_rtx[`LLCB_B_RETRY_LIM]; // RULE12
        link_d.twowire_retry_on = r_rtx[`LLCB_B_TW_RETRY]; // RULE12
        link_d.input_skew_comp = r_rtx[`LLCB_B_SKEW_COMP]; // RULE12
        link_d.input_retry_on = r_rtx[`LLCB_B_IN_RETRY]; // RULE12
        link_d.sync_bit_source = hv_d;
        link_d.double_output = r_bus[`LLCB_B_DOUBLE]; // RULE14
        link_d.half_rate_out = r_bus[`LLCB_B_HALF_RATE]; // RULE14
        link_d.bus_total_bits = wide ? 6'h20 : (hbw_eff ? 6'h1b : 6'h18); // RULE15
        link_d.bus_video_bits = wide ? 6'h1e : (hbw_eff ? 6'h18 : 6'h16); // RULE15
        link_d.bus_ctl_bits = hbw_eff ? 2'h3 : 2'h2; // RULE15
        link_d.sync_encoding_on = r_bus[`LLCB_B_SYNC_ENC];
        link_d.pixel_check_crc = local_side_on ? r_bus[`LLCB_B_PIX_CRC] : pix_sync_q[1]; // RULE16
        link_d.input_forward_on = r_side[`LLCB_B_IN_FWD]; // RULE17
        link_d.frame_sync_tx_on = r_side[`LLCB_B_FSYNC_TX]; // RULE17
        link_d.packet_side_mode = r_side[`LLCB_B_PKT_MODE]; // RULE18
        link_d.side_check_len = chk_d;
        link_d.de_glitch_filter = r_filt[`LLCB_B_DE_FILT]; // RULE22
        link_d.hs_glitch_filter = r_filt[`LLCB_B_HS_FILT]; // RULE22
        link_d.vs_glitch_filter = r_filt[`LLCB_B_VS_FILT]; // RULE22
        link_d.separate_de_on = r_filt[`LLCB_B_SEP_DE]; // RULE22
    end

    // ----------------------------------------
    // side channel, lock and error status
    // ----------------------------------------
    wire far_d = far_start && !r_eq[`LLCB_B_NO_FAR]; // RULE9
    wire lack_d = r_ack[`LLCB_B_LOC_ACK] && !fwd_avail; // RULE19
    wire hlock_d = hlock_in && (!r_ack[`LLCB_B_LINE_FOLLOW] || vlock_in); // RULE20
    wire thr_d = (r_thr != 8'h00) && (err_count >= r_thr); // RULE21

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            link_q <= '0;
            boost_q <= 4'h9;
            far_start_q <= 1'b0;
            local_ack_q <= 1'b0;
            hlock_q <= 1'b0;
            thr_reached_q <= 1'b0;
        end else begin
            link_q <= link_d;
            boost_q <= boost_d;
            far_start_q <= far_d;
            local_ack_q <= lack_d;
            hlock_q <= hlock_d;
            thr_reached_q <= thr_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_thr_write;
        reg_wr && reg_addr == `LLCB_OFS_THR;
    endsequence

    sequence s_thr_read;
        reg_rd && !reg_wr && reg_addr == `LLCB_OFS_THR;
    endsequence

    property p_thr_readback;
        logic [7:0] v;
        (s_thr_write, v = reg_wdata) ##1 s_thr_read |=> reg_ack_q && reg_rdata_q == v;
    endproperty
    a_thr_readback: assert property (p_thr_readback) else $error("threshold readback wrong"); // RULE21

    property p_reverse_route;
        (r_route[7:5] == 3'h4) |=> ctl_pin_o_q == {$past(ctl_int[0]), $past(ctl_int[1]),
            $past(ctl_int[2]), $past(ctl_int[3]), $past(ctl_int[4])};
    endproperty
    a_reverse_route: assert property (p_reverse_route) else $error("reversed order wrong"); // RULE1

    property p_pin_enable;
        (!out_dis && !reg_wr) |=> ctl_pin_oe_q == $past(r_route[4:0]);
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin enable mismatch"); // RULE2

    property p_out_disable;
        out_dis |=> ctl_pin_oe_q == 5'h00;
    endproperty
    a_out_disable: assert property (p_out_disable) else $error("outputs not disabled"); // RULE4

    property p_rate_auto;
        (r_rate[1:0] == 2'h3) |=> link_q.rate == LLCB_RATE_AUTO;
    endproperty
    a_rate_auto: assert property (p_rate_auto) else $error("rate auto not decoded"); // RULE3

    property p_boost_hold;
        (eq_run && !adaptive_eq_on && !boost_ok) [*2] |=> $stable(link_q.manual_boost);
    endproperty
    a_boost_hold: assert property (p_boost_hold) else $error("reserved boost applied"); // RULE10

    property p_strap_load;
        him_load |=> r_rtx[`LLCB_B_HIGH_IMM] == $past(him_sync_q[1]) ##1
            link_q.high_immunity == $past(r_rtx[`LLCB_B_HIGH_IMM]);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not loaded"); // RULE11

    property p_far_block;
        r_eq[`LLCB_B_NO_FAR] |=> !far_start_q;
    endproperty
    a_far_block: assert property (p_far_block) else $error("far start passed"); // RULE9

    property p_local_ack;
        (r_ack[`LLCB_B_LOC_ACK] && !fwd_avail) |=> local_ack_q;
    endproperty
    a_local_ack: assert property (p_local_ack) else $error("local ack missing"); // RULE19

    property p_line_follow;
        (r_ack[`LLCB_B_LINE_FOLLOW] && !vlock_in) |=> !hlock_q;
    endproperty
    a_line_follow: assert property (p_line_follow) else $error("line lock kept"); // RULE20

    property p_thr_hit;
        (r_thr != 8'h00 && err_count >= r_thr) |=> thr_reached_q;
    endproperty
    a_thr_hit: assert property (p_thr_hit) else $error("threshold not flagged"); // RULE21

    property p_hbw_legacy;
        hbw_eff |=> !link_q.prbs_style;
    endproperty
    a_hbw_legacy: assert property (p_hbw_legacy) else $error("prbs style not legacy"); // RULE23

endmodule

//--- rtl/llcb_cfg.svh
// llcb: register offsets, field positions, reset values and masks
`ifndef LLCB_CFG_SVH
`define LLCB_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LLCB_OFS_RATE 16'h0c02
`define LLCB_OFS_CHAN 16'h0c04
`define LLCB_OFS_EQ 16'h0c05
`define LLCB_OFS_RTX 16'h0c06
`define LLCB_OFS_BUS 16'h0c07
`define LLCB_OFS_SIDE 16'h0c08
`define LLCB_OFS_ACK 16'h0c0d
`define LLCB_OFS_THR 16'h0c0e
`define LLCB_OFS_FILT 16'h0c0f
`define LLCB_OFS_ROUTE 16'h0cd1
// ----------------------------------------
// register indices, count
// ----------------------------------------
`define LLCB_IX_RATE 4'h0
`define LLCB_IX_CHAN 4'h1
`define LLCB_IX_EQ 4'h2
`define LLCB_IX_RTX 4'h3
`define LLCB_IX_BUS 4'h4
`define LLCB_IX_SIDE 4'h5
`define LLCB_IX_ACK 4'h6
`define LLCB_IX_THR 4'h7
`define LLCB_IX_FILT 4'h8
`define LLCB_IX_ROUTE 4'h9
`define LLCB_IX_NONE 4'hf
`define LLCB_NREG 10
// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define LLCB_RST_VALS {8'h00, 8'h09, 8'h00, 8'h00, 8'h21, 8'h00, 8'h6f, 8'h39, 8'h03, 8'h03}
`define LLCB_WR_MASKS {8'hff, 8'h79, 8'hff, 8'h84, 8'h37, 8'hed, 8'hff, 8'hff, 8'h6b, 8'h03}
// ----------------------------------------
// field positions
// ----------------------------------------
`define LLCB_B_OUT_DIS 6
`define LLCB_B_PRBS_ON 5
`define LLCB_B_PORT_SEL 3
`define LLCB_B_REV_RX 1
`define LLCB_B_FWD_TX 0
`define LLCB_B_SKIP_ADDR 7
`define LLCB_B_NO_FAR 6
`define LLCB_B_TRACK_STY 5
`define LLCB_B_EQ_ON 4
`define LLCB_B_HIGH_IMM 7
`define LLCB_B_RETRY_LIM 6
`define LLCB_B_TW_RETRY 5
`define LLCB_B_SKEW_COMP 4
`define LLCB_B_IN_RETRY 3
`define LLCB_B_DOUBLE 7
`define LLCB_B_HALF_RATE 6
`define LLCB_B_WIDE 5
`define LLCB_B_HIGH_BW 3
`define LLCB_B_SYNC_ENC 2
`define LLCB_B_PIX_CRC 0
`define LLCB_B_IN_FWD 5
`define LLCB_B_FSYNC_TX 4
`define LLCB_B_PKT_MODE 2
`define LLCB_B_LOC_ACK 7
`define LLCB_B_LINE_FOLLOW 2
`define LLCB_B_DE_FILT 6
`define LLCB_B_HS_FILT 5
`define LLCB_B_VS_FILT 4
`define LLCB_B_SEP_DE 3
`define LLCB_B_PRBS_STY 0
`define LLCB_MAX_BOOST 4'hb
`endif

//--- rtl/llcb_pkg.sv
// llcb: shared types for the link configuration bank
package llcb_pkg;
    typedef enum logic [1:0] {
        LLCB_RATE_LOW = 2'h0, LLCB_RATE_MID = 2'h1, LLCB_RATE_HIGH = 2'h2, LLCB_RATE_AUTO = 2'h3
    } llcb_rate_e;
    typedef enum logic [5:0] {
        LLCB_HV_D18 = 6'h01, LLCB_HV_D14 = 6'h02, LLCB_HV_D12 = 6'h04,
        LLCB_HV_D0 = 6'h08, LLCB_HV_AUTO = 6'h10, LLCB_HV_RSVD = 6'h20
    } llcb_sync_bit_source_e;
    typedef enum logic [3:0] {
        LLCB_CHK_1 = 4'h1, LLCB_CHK_5 = 4'h2, LLCB_CHK_8 = 4'h4, LLCB_CHK_RSVD = 4'h8
    } llcb_chk_len_e;
    typedef struct packed {
        llcb_rate_e rate;
        logic outputs_off;
        logic prbs_test_on;
        logic prbs_style;
        logic side_port_select;
        logic reverse_side_rx_on;
        logic forward_side_tx_on;
        logic skip_reg_addr;
        logic sync_tracking_style;
        logic equalizer_run;
        logic [3:0] manual_boost;
        logic high_immunity;
        logic retry_limit_on;
        logic twowire_retry_on;
        logic input_skew_comp;
        logic input_retry_on;
        llcb_sync_bit_source_e sync_bit_source;
        logic double_output;
        logic half_rate_out;
        logic [5:0] bus_total_bits;
        logic [5:0] bus_video_bits;
        logic [1:0] bus_ctl_bits;
        logic sync_encoding_on;
        logic pixel_check_crc;
        logic input_forward_on;
        logic frame_sync_tx_on;
        logic packet_side_mode;
        llcb_chk_len_e side_check_len;
        logic de_glitch_filter;
        logic hs_glitch_filter;
        logic vs_glitch_filter;
        logic separate_de_on;
    } llcb_link_s;
endpackage

//--- verification/llcb_far_model.sv
// llcb: far side serializer model driving the link status inputs
`timescale 1ns/1ps
module llcb_far_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic send_start,
    input wire logic link_up,
    input wire logic hold_v,
    input wire logic inject_err,
    output logic far_start,
    output logic fwd_avail,
    output logic hlock_in,
    output logic vlock_in,
    output logic [7:0] err_count
);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            far_start <= 1'b0;
            fwd_avail <= 1'b0;
            hlock_in <= 1'b0;
            vlock_in <= 1'b0;
            err_count <= 8'h00;
        end else begin
            far_start <= send_start;
            fwd_avail <= link_up;
            hlock_in <= link_up;
            vlock_in <= link_up & ~hold_v;
            if (inject_err && err_count != 8'hff) begin
                err_count <= err_count + 8'h01;
            end
        end
    end
endmodule

//--- verification/llcb_bank_tb_top.sv
// llcb: self-checking bench for the link configuration bank
`timescale 1ns/1ps
`include "llcb_cfg.svh"
module llcb_bank_tb_top
    import llcb_pkg::*;
;
    logic clk_sys, rst_n, reg_wr, reg_rd, reg_ack_q, him_cfg_pin, pix_check_pin;
    logic local_side_on, adaptive_eq_on, fwd_avail, far_start, far_start_q, local_ack_q;
    logic hlock_in, vlock_in, hlock_q, thr_reached_q, send_start, link_up, hold_v, inject_err;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, err_count;
    logic [4:0] ctl_int, ctl_pin_o_q, ctl_pin_oe_q;
    llcb_link_s link_q;
    logic [31:0] rng;
    logic [15:0] ofs [10];
    logic [7:0] msk [10];
    logic [7:0] shadow [10];
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    llcb_bank llcb_bank_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_ack_q(reg_ack_q), .ctl_int(ctl_int), .ctl_pin_o_q(ctl_pin_o_q),
        .ctl_pin_oe_q(ctl_pin_oe_q), .him_cfg_pin(him_cfg_pin), .pix_check_pin(pix_check_pin),
        .local_side_on(local_side_on), .adaptive_eq_on(adaptive_eq_on), .fwd_avail(fwd_avail),
        .far_start(far_start), .far_start_q(far_start_q), .local_ack_q(local_ack_q),
        .hlock_in(hlock_in), .vlock_in(vlock_in), .hlock_q(hlock_q), .err_count(err_count),
        .thr_reached_q(thr_reached_q), .link_q(link_q));
    llcb_far_model llcb_far_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .send_start(send_start), .link_up(link_up), .hold_v(hold_v), .inject_err(inject_err),
        .far_start(far_start), .fwd_avail(fwd_avail), .hlock_in(hlock_in),
        .vlock_in(vlock_in), .err_count(err_count));

    // ----------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [4:0] route(input logic [2:0] c, input logic [4:0] v);
        logic [4:0] r;
        for (int p = 0; p < 5; p++) begin
            r[p] = v[(c < 4) ? (p - c + 5) % 5 : (c - p + 5) % 5];
        end
        return r;
    endfunction
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int i, input logic [7:0] v);
        reg_addr = ofs[i];
        reg_wdata = v;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        shadow[i] = v & msk[i];
        step(1);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        chk(reg_ack_q, 8'h01);
        chk(reg_rdata_q, exp);
        step(1);
    endtask
    task automatic chk_link(input int i);
        logic [7:0] v;
        logic hb;
        v = shadow[i];
        hb = shadow[4][3] & ~shadow[4][5];
        case (i)
            0: chk(link_q.rate, v[1:0]);
            1: chk({link_q.outputs_off, link_q.prbs_test_on, link_q.side_port_select,
                link_q.reverse_side_rx_on, link_q.forward_side_tx_on}, {v[6:5], v[3], v[1:0]});
            2: begin
                chk({link_q.skip_reg_addr, link_q.sync_tracking_style, link_q.equalizer_run},
                    {v[7], v[5:4]});
                chk(link_q.manual_boost, (v[4] & ~adaptive_eq_on) ? v[3:0] : 4'h0);
            end
            3: begin
                chk({link_q.high_immunity, link_q.retry_limit_on, link_q.twowire_retry_on,
                    link_q.input_skew_comp, link_q.input_retry_on}, v[7:3]);
                chk(link_q.sync_bit_source, v[2] ? (v[1] ? 8'h10 : 8'h20) : 8'h01 << v[1:0]);
            end
            4: begin
                chk({link_q.double_output, link_q.half_rate_out, link_q.sync_encoding_on,
                    link_q.pixel_check_crc}, {v[7:6], v[2], v[0]});
                chk(link_q.bus_total_bits, v[5] ? 8'd32 : (hb ? 8'd27 : 8'd24));
                chk({link_q.bus_video_bits, link_q.bus_ctl_bits},
                    {v[5] ? 6'd30 : (hb ? 6'd24 : 6'd22), hb ? 2'd3 : 2'd2});
            end
            5: begin
                chk({link_q.input_forward_on, link_q.frame_sync_tx_on, link_q.packet_side_mode},
                    {v[5:4], v[2]});
                chk(link_q.side_check_len, v[1:0] == 2'h3 ? 8'h08 : 8'h01 << v[1:0]);
            end
            8: chk({link_q.de_glitch_filter, link_q.hs_glitch_filter, link_q.vs_glitch_filter,
                link_q.separate_de_on}, v[6:3]);
            default: ;
        endcase
        chk(link_q.prbs_style, shadow[8][0] & ~hb);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, ctl_int, pix_check_pin} = '0;
        {send_start, link_up, hold_v, inject_err, adaptive_eq_on, rst_n} = '0;
        him_cfg_pin = 1'b1;
        local_side_on = 1'b1;
        rng = 32'd5670;
        ofs = '{`LLCB_OFS_RATE, `LLCB_OFS_CHAN, `LLCB_OFS_EQ, `LLCB_OFS_RTX, `LLCB_OFS_BUS,
            `LLCB_OFS_SIDE, `LLCB_OFS_ACK, `LLCB_OFS_THR, `LLCB_OFS_FILT, `LLCB_OFS_ROUTE};
        msk = '{8'h03, 8'h6b, 8'hff, 8'hff, 8'hed, 8'h37, 8'h84, 8'hff, 8'h79, 8'hff};
        shadow = '{8'h03, 8'h03, 8'h39, 8'hef, 8'h00, 8'h21, 8'h00, 8'h00, 8'h09, 8'h00};
        step(10);
        rst_n = 1'b1;
        step(2);
        for (int i = 0; i < 10; i++) begin
            rd_chk(ofs[i], shadow[i]);
            chk_link(i);
        end
        rd_chk(16'h0c03, 8'h00);
        for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            wr(8, {rng[15:9], 1'b0});
            chk_link(8);
            wr(0, {rng[7:2], c[1:0]});
            chk_link(0);
            wr(3, {rng[7:3], c[2:0]});
            chk_link(3);
            wr(5, {rng[23:18], c[1:0]});
            chk_link(5);
            wr(4, {c[2], c[2], c[1], 1'b0, c[0], c[0], 1'b0, c[2]});
            chk_link(4);
        end
        for (int b = 0; b < 12; b++) begin
            rng = xs(rng);
            adaptive_eq_on = rng[8];
            wr(2, {rng[7:4], b[3:0]});
            chk_link(2);
        end
        adaptive_eq_on = 1'b0;
        wr(2, 8'h1b);
        wr(2, 8'h1c);
        chk(link_q.manual_boost, 8'h0b);
        wr(2, 8'h39);
        for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            ctl_int = rng[4:0];
            wr(9, {c[2:0], 5'h1f});
            chk(ctl_pin_o_q, route(c[2:0], ctl_int));
            chk(ctl_pin_oe_q, 8'h1f);
            wr(9, {c[2:0], rng[12:8]});
            chk(ctl_pin_oe_q, rng[12:8]);
        end
        wr(1, 8'h6b);
        chk(ctl_pin_oe_q, 8'h00);
        chk_link(1);
        for (int n = 0; n < 40; n++) begin
            int i;
            logic [7:0] v;
            rng = xs(rng);
            i = rng[31:8] % 10;
            v = rng[7:0];
            if (i == 2 && v[3:0] > 4'hb) v[3] = 1'b0;
            if (i == 8 && shadow[4][3] && !shadow[4][5]) v[0] = 1'b0;
            if (i == 4 && shadow[8][0]) v[3] = 1'b0;
            wr(i, v);
            chk_link(i);
            rd_chk(ofs[i], shadow[i]);
        end
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            link_up = k[2];
            hold_v = rng[0];
            wr(6, {k[0], 4'h0, k[1], 2'h0});
            step(2);
            chk({local_ack_q, hlock_q}, {k[0] & ~k[2], k[2] & ~(k[1] & hold_v)});
            rd_chk(ofs[6], shadow[6]);
        end
        for (int k = 0; k < 2; k++) begin
            wr(2, 8'h39 | {1'b0, k[0], 6'h00});
            send_start = 1'b1;
            step(1);
            send_start = 1'b0;
            step(1);
            chk(far_start_q, !k[0]);
            step(1);
            chk(far_start_q, 8'h00);
        end
        reg_addr = ofs[7];
        reg_wdata = 8'h03;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        shadow[7] = 8'h03;
        rd_chk(ofs[7], 8'h03);
        for (int k = 1; k < 6; k++) begin
            inject_err = 1'b1;
            step(1);
            inject_err = 1'b0;
            step(2);
            chk(thr_reached_q, k >= 3);
        end
        wr(7, 8'h00);
        chk(thr_reached_q, 8'h00);
        local_side_on = 1'b0;
        pix_check_pin = 1'b1;
        step(5);
        chk(link_q.pixel_check_crc, 8'h01);
        results();
    end
endmodule
